// file: bench/cmsv_tb.sv
// self-checking bench for the cpu mode select and vector map block
`timescale 1ns/1ps
module testbench;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ce_in = 1'b1;
	logic [3:0] reg_addr_in = 4'h0;
	logic [3:0] reg_wdata_in = 4'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [3:0] reg_rdata_out;
	logic op_valid_in = 1'b0;
	cmsv_pkg::cmsv_op_e op_kind_in = cmsv_pkg::OP_CALL_ABS;
	logic [13:0] pc_in = 14'h0000;
	logic [13:0] operand_in = 14'h0000;
	logic [15:0] data_in = 16'h0000;
	logic mbe_in = 1'b0;
	logic rbe_in = 1'b0;
	logic busy_out;
	logic illegal_out;
	logic target_valid_out;
	logic [13:0] target_pc_out;
	logic push_valid_out;
	logic [1:0] push_index_out;
	logic [7:0] push_data_out;
	logic stack_bank_out;
	logic legacy_mode_out;
	logic vec_mbe_out;
	logic vec_rbe_out;
	int err_total = 0;
	int cmp_count = 0;
	// first four offsets reachable, last four just outside the window
	logic [5:0] rel_off [8] = '{6'h31, 6'h3f, 6'h02, 6'h10, 6'h00, 6'h01, 6'h30, 6'h11};
	logic [13:0] vec_tab [6] = '{14'h0000, 14'h0002, 14'h0004, 14'h0008, 14'h000a, 14'h000c};
	logic [13:0] tab_adr [5] = '{14'h0020, 14'h007e, 14'h001e, 14'h0080, 14'h0021};

	cmsv_top u_dut (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.op_valid_in(op_valid_in), .op_kind_in(op_kind_in), .pc_in(pc_in),
		.operand_in(operand_in), .data_in(data_in), .mbe_in(mbe_in), .rbe_in(rbe_in),
		.busy_out(busy_out), .illegal_out(illegal_out),
		.target_valid_out(target_valid_out), .target_pc_out(target_pc_out),
		.push_valid_out(push_valid_out), .push_index_out(push_index_out),
		.push_data_out(push_data_out), .stack_bank_out(stack_bank_out),
		.legacy_mode_out(legacy_mode_out), .vec_mbe_out(vec_mbe_out),
		.vec_rbe_out(vec_rbe_out)
	);

	always #10 clk_in = ~clk_in;

	task automatic test_done;
		if (err_total == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic reg_write(input logic [3:0] adr, input logic [3:0] dat);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= adr;
		reg_wdata_in <= dat;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask : reg_write

	// read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] adr, input logic [3:0] exp);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= adr;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		check("reg_rdata", {12'h000, reg_rdata_out}, {12'h000, exp});
	endtask : reg_read

	// one operation; cycles counted from the take edge to the finish pulse
	task automatic run_op(input cmsv_pkg::cmsv_op_e k, input logic [13:0] pc,
		input logic [13:0] opd, input logic [15:0] dat, input logic [1:0] fl,
		input int ill, input int ncyc, input logic [13:0] tgt, input int npush, input int tv);
		int n;
		int np;
		logic [7:0] eb;
		@(posedge clk_in);
		op_valid_in <= 1'b1;
		op_kind_in <= k;
		pc_in <= pc;
		operand_in <= opd;
		data_in <= dat;
		mbe_in <= fl[1];
		rbe_in <= fl[0];
		@(posedge clk_in);
		op_valid_in <= 1'b0;
		np = 0;
		// the take cycle is looked at too: a refusal pulses only there
		for (n = 0; n <= 6; n++)
		begin
			if (n > 0)
				@(posedge clk_in);
			#1;
			if (push_valid_out === 1'b1)
			begin
				eb = (np == 0) ? pc[7:0] :
					(np == 1) ? {fl, 2'b00, pc[11:8]} : {6'h00, pc[13:12]};
				check("push_index", {14'h0, push_index_out}, 16'(np));
				check("push_data", {8'h00, push_data_out}, {8'h00, eb});
				np++;
			end
			if (illegal_out === 1'b1 || target_valid_out === 1'b1)
				break;
			check("busy", {15'h0, busy_out}, 16'h0001);
		end
		check("illegal", {15'h0, illegal_out}, 16'(ill));
		check("cycles", 16'(n), 16'(ill != 0 ? 0 : ncyc));
		check("pushes", 16'(np), 16'(npush));
		if (tv != 0 && ill == 0)
			check("target", {2'b00, target_pc_out}, {2'b00, tgt});
	endtask : run_op

	initial
	begin
		repeat (20000) @(posedge clk_in);
		err_total++;
		test_done();
	end

	initial
	begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		check("legacy_mode", {15'h0, legacy_mode_out}, 16'h0001);
		reg_read(cmsv_pkg::REG_SBS, 4'h8);
		reg_read(cmsv_pkg::REG_STAT, 4'h4);
		reg_write(cmsv_pkg::REG_SBS, 4'h9);
		reg_write(cmsv_pkg::REG_SBS, 4'hf);
		#1;
		check("stack_bank", {15'h0, stack_bank_out}, 16'h0001);
		reg_read(cmsv_pkg::REG_SBS, 4'h9);
		reg_write(4'h7, 4'h0);
		reg_read(4'h7, 4'h0);
		reg_read(cmsv_pkg::REG_SBS, 4'h9);
		// legacy mode: short stack, short calls, no far opcodes
		run_op(cmsv_pkg::OP_CALL_ABS, 14'h3a5c, 14'h2001, 16'h0, 2'h1, 0, 3, 14'h2001, 2, 1);
		run_op(cmsv_pkg::OP_CALL_FIXED, 14'h1234, 14'h07ff, 16'h0, 2'h2, 0, 2, 14'h07ff, 2, 1);
		run_op(cmsv_pkg::OP_FAR_JUMP, 14'h0100, 14'h3000, 16'h0, 2'h0, 1, 0, 14'h0, 0, 0);
		run_op(cmsv_pkg::OP_FAR_CALL, 14'h0100, 14'h3000, 16'h0, 2'h0, 1, 0, 14'h0, 0, 0);
		reg_read(cmsv_pkg::REG_STAT, 4'h6);
		reg_write(cmsv_pkg::REG_STAT, 4'h2);
		reg_read(cmsv_pkg::REG_STAT, 4'h4);
		// switch to extended mode in bank 1, then back to bank 0
		reg_write(cmsv_pkg::REG_SBS, 4'h1);
		#1;
		check("legacy_mode", {15'h0, legacy_mode_out}, 16'h0000);
		check("stack_bank", {15'h0, stack_bank_out}, 16'h0001);
		reg_write(cmsv_pkg::REG_SBS, 4'h0);
		#1;
		check("stack_bank", {15'h0, stack_bank_out}, 16'h0000);
		reg_read(cmsv_pkg::REG_STAT, 4'h0);
		// a write while the clock enable is low must not reach the mode bit
		ce_in <= 1'b0;
		reg_write(cmsv_pkg::REG_SBS, 4'h8);
		ce_in <= 1'b1;
		#1;
		check("legacy_mode", {15'h0, legacy_mode_out}, 16'h0000);
		run_op(cmsv_pkg::OP_CALL_ABS, 14'h3a5c, 14'h2001, 16'h0, 2'h2, 0, 4, 14'h2001, 3, 1);
		run_op(cmsv_pkg::OP_CALL_FIXED, 14'h2e01, 14'h0400, 16'h0, 2'h3, 0, 3, 14'h0400, 3, 1);
		run_op(cmsv_pkg::OP_FAR_JUMP, 14'h0100, 14'h3abc, 16'h0, 2'h0, 0, 3, 14'h3abc, 0, 1);
		run_op(cmsv_pkg::OP_FAR_CALL, 14'h1f80, 14'h2222, 16'h0, 2'h1, 0, 3, 14'h2222, 3, 1);
		for (int i = 0; i < 8; i++)
			run_op(cmsv_pkg::OP_REL_JUMP, 14'h0100, {8'h00, rel_off[i]}, 16'h0, 2'h0, i > 3, 2,
				14'h0100 + {{8{rel_off[i][5]}}, rel_off[i]}, 0, 1);
		for (int i = 0; i < 8; i++)
			run_op(cmsv_pkg::OP_VEC_LOOKUP, 14'h0100, 14'(i), 16'h0, 2'h0, i > 5, 2,
				(i < 6) ? vec_tab[i] : 14'h0, 0, 1);
		for (int i = 0; i < 5; i++)
			run_op(cmsv_pkg::OP_TABLE, 14'h0100, tab_adr[i], 16'h0, 2'h0, i > 1, 3, 14'h0, 0, 0);
		run_op(cmsv_pkg::OP_BLOCK_JUMP, 14'h2345, 14'h0fff, 16'h0, 2'h0, 0, 2, 14'h2fff, 0, 1);
		run_op(cmsv_pkg::OP_BLOCK_JUMP, 14'h1000, 14'h0000, 16'h0, 2'h0, 0, 2, 14'h1000, 0, 1);
		run_op(cmsv_pkg::OP_PAGE_DE, 14'h1234, 14'h0, 16'h0056, 2'h0, 0, 3, 14'h1256, 0, 1);
		run_op(cmsv_pkg::OP_PAGE_XA, 14'h2fab, 14'h0, 16'h0012, 2'h0, 0, 3, 14'h2f12, 0, 1);
		run_op(cmsv_pkg::OP_VEC_DISPATCH, 14'h0100, 14'h0, 16'h8123, 2'h0, 0, 2, 14'h0123, 0, 1);
		check("vec_flags", {14'h0, vec_mbe_out, vec_rbe_out}, 16'h0002);
		run_op(cmsv_pkg::OP_VEC_DISPATCH, 14'h0100, 14'h0, 16'h7fff, 2'h0, 0, 2, 14'h3fff, 0, 1);
		check("vec_flags", {14'h0, vec_mbe_out, vec_rbe_out}, 16'h0001);
		// reset in mid-run must bring back legacy mode and bank 0
		rst_in <= 1'b1;
		@(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		check("legacy_mode", {15'h0, legacy_mode_out}, 16'h0001);
		check("stack_bank", {15'h0, stack_bank_out}, 16'h0000);
		reg_read(cmsv_pkg::REG_SBS, 4'h8);
		run_op(cmsv_pkg::cmsv_op_e'(4'hf), 14'h0100, 14'h0, 16'h0, 2'h0, 1, 0, 14'h0, 0, 0);
		test_done();
	end
endmodule : testbench

// file: design/cmsv_pkg.sv
// constants, types and helpers for the cpu mode select and vector map block
package cmsv_pkg;

	// register indices on the plain register port
	localparam logic [3:0] REG_SBS = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h1;

	// stack bank select register layout
	localparam int SBS_MODE_BIT = 3;
	localparam int SBS_BANK_BIT = 0;
	localparam logic [3:0] SBS_RESET = 4'h8;
	localparam logic [3:0] SBS_WMASK = 4'h9;

	// status register layout
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ILL_BIT = 1;
	localparam int STAT_MODE_BIT = 2;

	// stack bytes per call
	localparam logic [1:0] PUSH_LEG = 2'h2;
	localparam logic [1:0] PUSH_EXT = 2'h3;

	// machine cycles per operation
	localparam logic [2:0] CYC_CALL_LEG = 3'h3;
	localparam logic [2:0] CYC_CALL_EXT = 3'h4;
	localparam logic [2:0] CYC_FCALL_LEG = 3'h2;
	localparam logic [2:0] CYC_FCALL_EXT = 3'h3;
	localparam logic [2:0] CYC_FAR = 3'h3;
	localparam logic [2:0] CYC_BLOCK = 3'h2;
	localparam logic [2:0] CYC_REL = 3'h2;
	localparam logic [2:0] CYC_PAGE = 3'h3;
	localparam logic [2:0] CYC_TABLE = 3'h3;
	localparam logic [2:0] CYC_VEC = 3'h2;

	// program memory layout
	localparam int PC_MSB = 13;
	localparam int BLOCK_LSB = 12;
	localparam int PAGE_BITS = 8;
	localparam int FADDR_BITS = 11;
	localparam int LEG_PC_MSB = 11;
	localparam logic [13:0] VEC_RESET = 14'h0000;
	localparam logic [13:0] VEC_ITMR_B = 14'h0002;
	localparam logic [13:0] VEC_EDGE_A = 14'h0004;
	localparam logic [13:0] VEC_SERIAL = 14'h0008;
	localparam logic [13:0] VEC_TMR0 = 14'h000a;
	localparam logic [13:0] VEC_TMR12 = 14'h000c;
	localparam logic [13:0] TABLE_LO = 14'h0020;
	localparam logic [13:0] TABLE_HI = 14'h007f;
	localparam logic signed [6:0] REL_MIN = -7'sh0f;
	localparam logic signed [6:0] REL_NEG_MAX = -7'sh01;
	localparam logic signed [6:0] REL_POS_MIN = 7'sh02;
	localparam logic signed [6:0] REL_MAX = 7'sh10;

	// vector entry word: flags in bits 7 and 6 of the upper byte
	localparam int ENT_MBE_BIT = 15;
	localparam int ENT_RBE_BIT = 14;

	// interrupt sources for the vector lookup
	localparam logic [2:0] SRC_RESET = 3'h0;
	localparam logic [2:0] SRC_ITMR_B = 3'h1;
	localparam logic [2:0] SRC_EDGE_A = 3'h2;
	localparam logic [2:0] SRC_SERIAL = 3'h3;
	localparam logic [2:0] SRC_TMR0 = 3'h4;
	localparam logic [2:0] SRC_TMR12 = 3'h5;

	typedef enum logic [3:0] {
		OP_CALL_ABS = 4'h0,
		OP_CALL_FIXED = 4'h1,
		OP_FAR_JUMP = 4'h2,
		OP_FAR_CALL = 4'h3,
		OP_BLOCK_JUMP = 4'h4,
		OP_REL_JUMP = 4'h5,
		OP_PAGE_DE = 4'h6,
		OP_PAGE_XA = 4'h7,
		OP_TABLE = 4'h8,
		OP_VEC_LOOKUP = 4'h9,
		OP_VEC_DISPATCH = 4'ha
	} cmsv_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} cmsv_state_e;

	typedef struct packed {
		cmsv_state_e state;
		logic [3:0] stack_bank_select;
		logic ill_sticky;
		logic [2:0] cnt;
		logic [2:0] ncyc;
		logic [1:0] nbytes;
		logic [13:0] ret;
		logic [13:0] tgt;
		logic memory_bank_enable_flag;
		logic register_bank_enable_flag;
		logic busy;
		logic illegal;
		logic tvalid;
		logic [3:0] rdata;
		logic pvalid;
		logic [1:0] pidx;
		logic [7:0] pdata;
		logic vmbe;
		logic vrbe;
	} cmsv_regs_s;

	function automatic logic is_call(input cmsv_op_e k);
		return (k == OP_CALL_ABS) || (k == OP_CALL_FIXED) || (k == OP_FAR_CALL);
	endfunction : is_call

	function automatic logic [1:0] push_bytes(input cmsv_op_e k, input logic leg);
		if (!is_call(k))
			return 2'h0;
		return leg ? PUSH_LEG : PUSH_EXT;
	endfunction : push_bytes

	function automatic logic [2:0] op_cycles(input cmsv_op_e k, input logic leg);
		unique case (k)
			OP_CALL_ABS: return leg ? CYC_CALL_LEG : CYC_CALL_EXT;
			OP_CALL_FIXED: return leg ? CYC_FCALL_LEG : CYC_FCALL_EXT;
			OP_FAR_JUMP, OP_FAR_CALL: return CYC_FAR;
			OP_BLOCK_JUMP: return CYC_BLOCK;
			OP_REL_JUMP: return CYC_REL;
			OP_PAGE_DE, OP_PAGE_XA: return CYC_PAGE;
			OP_TABLE: return CYC_TABLE;
			default: return CYC_VEC;
		endcase
	endfunction : op_cycles

endpackage : cmsv_pkg

// file: design/cmsv_target_calc.sv
// branch target and legality per operation kind
`timescale 1ns/1ps
module cmsv_target_calc (
	input cmsv_pkg::cmsv_op_e kind_in,
	input logic legacy_in,
	input logic [13:0] pc_in,
	input logic [13:0] operand_in,
	input logic [7:0] pair_in,
	input logic [13:0] vec_addr_in,
	input logic vec_ok_in,
	input logic [13:0] entry_start_in,
	output logic [13:0] target_out,
	output logic legal_out
);

	logic signed [6:0] off;
	logic rel_ok;

	assign off = {operand_in[5], operand_in[5:0]};
	// offsets 0 and +1 are not encodable
	assign rel_ok = ((off >= cmsv_pkg::REL_MIN) && (off <= cmsv_pkg::REL_NEG_MAX))
		|| ((off >= cmsv_pkg::REL_POS_MIN) && (off <= cmsv_pkg::REL_MAX));

	always_comb
	begin
		legal_out = 1'b1;
		target_out = operand_in;
		unique case (kind_in)
			cmsv_pkg::OP_CALL_ABS: target_out = operand_in;
			cmsv_pkg::OP_CALL_FIXED:
				target_out = {3'h0, operand_in[cmsv_pkg::FADDR_BITS-1:0]};
			cmsv_pkg::OP_FAR_JUMP, cmsv_pkg::OP_FAR_CALL: legal_out = !legacy_in;
			cmsv_pkg::OP_BLOCK_JUMP:
				target_out = {pc_in[cmsv_pkg::PC_MSB:cmsv_pkg::BLOCK_LSB],
					operand_in[cmsv_pkg::BLOCK_LSB-1:0]};
			cmsv_pkg::OP_REL_JUMP:
			begin
				target_out = pc_in + {{7{off[6]}}, off};
				legal_out = rel_ok;
			end
			cmsv_pkg::OP_PAGE_DE, cmsv_pkg::OP_PAGE_XA:
				target_out = {pc_in[cmsv_pkg::PC_MSB:cmsv_pkg::PAGE_BITS], pair_in};
			cmsv_pkg::OP_TABLE:
				legal_out = (operand_in >= cmsv_pkg::TABLE_LO)
					&& (operand_in <= cmsv_pkg::TABLE_HI) && !operand_in[0];
			cmsv_pkg::OP_VEC_LOOKUP:
			begin
				target_out = vec_addr_in;
				legal_out = vec_ok_in;
			end
			cmsv_pkg::OP_VEC_DISPATCH: target_out = entry_start_in;
			default:
			begin
				target_out = pc_in;
				legal_out = 1'b0;
			end
		endcase
	end

endmodule : cmsv_target_calc

// file: design/cmsv_top.sv
// cpu mode select register, call sequencer and program memory target map
`timescale 1ns/1ps
module cmsv_top (
	input logic clk_in,
	input logic rst_in,
	input logic ce_in,
	input logic [3:0] reg_addr_in,
	input logic [3:0] reg_wdata_in,
	input logic reg_wr_in,
	input logic reg_rd_in,
	output logic [3:0] reg_rdata_out,
	input logic op_valid_in,
	input cmsv_pkg::cmsv_op_e op_kind_in,
	input logic [13:0] pc_in,
	input logic [13:0] operand_in,
	input logic [15:0] data_in,
	input logic mbe_in,
	input logic rbe_in,
	output logic busy_out,
	output logic illegal_out,
	output logic target_valid_out,
	output logic [13:0] target_pc_out,
	output logic push_valid_out,
	output logic [1:0] push_index_out,
	output logic [7:0] push_data_out,
	output logic stack_bank_out,
	output logic legacy_mode_out,
	output logic vec_mbe_out,
	output logic vec_rbe_out
);

	localparam cmsv_pkg::cmsv_regs_s RESET_REGS = '{
		state: cmsv_pkg::ST_IDLE,
		stack_bank_select: cmsv_pkg::SBS_RESET,
		default: '0
	};

	cmsv_pkg::cmsv_regs_s st_q;
	cmsv_pkg::cmsv_regs_s st_d;
	logic [13:0] vec_addr;
	logic vec_ok;
	logic ent_mbe;
	logic ent_rbe;
	logic [13:0] ent_start;
	logic [13:0] calc_target;
	logic calc_legal;
	logic legacy;
	logic take;

	assign legacy = st_q.stack_bank_select[cmsv_pkg::SBS_MODE_BIT];
	assign take = op_valid_in && (st_q.state == cmsv_pkg::ST_IDLE);

	cmsv_vec_map u_vec (
		.src_in(operand_in[2:0]),
		.entry_in(data_in),
		.vec_addr_out(vec_addr),
		.vec_ok_out(vec_ok),
		.entry_mbe_out(ent_mbe),
		.entry_rbe_out(ent_rbe),
		.entry_start_out(ent_start)
	);

	cmsv_target_calc u_calc (
		.kind_in(op_kind_in),
		.legacy_in(legacy),
		.pc_in(pc_in),
		.operand_in(operand_in),
		.pair_in(data_in[cmsv_pkg::PAGE_BITS-1:0]),
		.vec_addr_in(vec_addr),
		.vec_ok_in(vec_ok),
		.entry_start_in(ent_start),
		.target_out(calc_target),
		.legal_out(calc_legal)
	);

	// byte 0 low pc, byte 1 flags and pc up to bit 11, byte 2 the rest
	function automatic logic [7:0] push_byte(input logic [1:0] idx, input logic [13:0] ret,
		input logic memory_bank_enable_flag, input logic register_bank_enable_flag);
		unique case (idx)
			2'h0: return ret[7:0];
			2'h1: return {memory_bank_enable_flag, register_bank_enable_flag, 2'h0, ret[cmsv_pkg::LEG_PC_MSB:8]};
			default: return {6'h00, ret[cmsv_pkg::PC_MSB:cmsv_pkg::LEG_PC_MSB+1]};
		endcase
	endfunction : push_byte

	function automatic logic [3:0] read_mux(input logic [3:0] addr,
		input cmsv_pkg::cmsv_regs_s s);
		logic [3:0] v;
		v = 4'h0;
		if (addr == cmsv_pkg::REG_SBS)
			v = s.stack_bank_select;
		else if (addr == cmsv_pkg::REG_STAT)
		begin
			v[cmsv_pkg::STAT_BUSY_BIT] = s.busy;
			v[cmsv_pkg::STAT_ILL_BIT] = s.ill_sticky;
			v[cmsv_pkg::STAT_MODE_BIT] = s.stack_bank_select[cmsv_pkg::SBS_MODE_BIT];
		end
		return v;
	endfunction : read_mux

	always_comb
	begin
		st_d = st_q;
		st_d.tvalid = 1'b0;
		st_d.illegal = 1'b0;
		st_d.pvalid = 1'b0;
		st_d.rdata = 4'h0;
		// reserved bits 2 and 1 are not stored and read as zero
		if (reg_wr_in && (reg_addr_in == cmsv_pkg::REG_SBS))
			st_d.stack_bank_select = reg_wdata_in & cmsv_pkg::SBS_WMASK;
		if (reg_wr_in && (reg_addr_in == cmsv_pkg::REG_STAT)
			&& reg_wdata_in[cmsv_pkg::STAT_ILL_BIT])
			st_d.ill_sticky = 1'b0;
		if (reg_rd_in)
			st_d.rdata = read_mux(reg_addr_in, st_q);
		unique case (st_q.state)
			cmsv_pkg::ST_IDLE:
			begin
				if (take && !calc_legal)
				begin
					// set after the clear above, so a same-cycle event wins
					st_d.illegal = 1'b1;
					st_d.ill_sticky = 1'b1;
				end
				else if (take)
				begin
					// mode is sampled once per operation; a later write acts on the next
					st_d.state = cmsv_pkg::ST_EXEC;
					st_d.busy = 1'b1;
					st_d.cnt = 3'h0;
					st_d.ncyc = cmsv_pkg::op_cycles(op_kind_in, legacy);
					st_d.nbytes = cmsv_pkg::push_bytes(op_kind_in, legacy);
					st_d.ret = pc_in;
					st_d.tgt = calc_target;
					st_d.memory_bank_enable_flag = mbe_in;
					st_d.register_bank_enable_flag = rbe_in;
					if (op_kind_in == cmsv_pkg::OP_VEC_DISPATCH)
					begin
						st_d.vmbe = ent_mbe;
						st_d.vrbe = ent_rbe;
					end
				end
			end
			cmsv_pkg::ST_EXEC:
			begin
				if (st_q.cnt < {1'b0, st_q.nbytes})
				begin
					st_d.pvalid = 1'b1;
					st_d.pidx = st_q.cnt[1:0];
					st_d.pdata = push_byte(st_q.cnt[1:0], st_q.ret, st_q.memory_bank_enable_flag, st_q.register_bank_enable_flag);
				end
				if (st_q.cnt == (st_q.ncyc - 3'h1))
				begin
					st_d.state = cmsv_pkg::ST_IDLE;
					st_d.busy = 1'b0;
					st_d.tvalid = 1'b1;
				end
				else
					st_d.cnt = st_q.cnt + 3'h1;
			end
			default:
			begin
				st_d.state = cmsv_pkg::ST_IDLE;
				st_d.busy = 1'b0;
			end
		endcase
	end

	// reset is honoured even while the clock enable is low
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			st_q <= RESET_REGS;
		else if (ce_in)
			st_q <= st_d;
	end

	assign reg_rdata_out = st_q.rdata;
	assign busy_out = st_q.busy;
	assign illegal_out = st_q.illegal;
	assign target_valid_out = st_q.tvalid;
	assign target_pc_out = st_q.tgt;
	assign push_valid_out = st_q.pvalid;
	assign push_index_out = st_q.pidx;
	assign push_data_out = st_q.pdata;
	assign stack_bank_out = st_q.stack_bank_select[cmsv_pkg::SBS_BANK_BIT];
	assign legacy_mode_out = st_q.stack_bank_select[cmsv_pkg::SBS_MODE_BIT];
	assign vec_mbe_out = st_q.vmbe;
	assign vec_rbe_out = st_q.vrbe;

	// helper state watched only by the checks below
	logic [2:0] hp_cnt;
	logic [2:0] hp_exp;
	logic [13:0] hp_ret;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			hp_cnt <= 3'h0;
			hp_exp <= 3'h0;
			hp_ret <= 14'h0000;
		end
		else if (ce_in)
		begin
			if (take && calc_legal)
			begin
				hp_cnt <= 3'h0;
				hp_exp <= cmsv_pkg::is_call(op_kind_in) ? (legacy ? 3'h2 : 3'h3) : 3'h0;
				hp_ret <= pc_in;
			end
			else if (push_valid_out)
				hp_cnt <= hp_cnt + 3'h1;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in || !ce_in);

	sequence take_s(cmsv_pkg::cmsv_op_e k, logic leg);
		op_valid_in && !busy_out && (op_kind_in == k) && (legacy_mode_out == leg);
	endsequence

	// finish pulse is registered on the last cycle, so it is sampled one edge later
	sequence done_after_3_s;
		##1 !target_valid_out [*3] ##1 target_valid_out;
	endsequence

	sequence done_after_4_s;
		##1 !target_valid_out [*4] ##1 target_valid_out;
	endsequence

	mode_write_a:
		assert property (reg_wr_in && (reg_addr_in == cmsv_pkg::REG_SBS)
			|=> legacy_mode_out == $past(reg_wdata_in[3]))
		else $error("mode bit does not follow register write");

	mode_reset_a:
		assert property (disable iff (1'b0) rst_in |=> legacy_mode_out && !busy_out)
		else $error("reset did not select legacy mode");

	push_count_a:
		assert property (target_valid_out |-> (hp_cnt + 3'(push_valid_out)) == hp_exp)
		else $error("wrong number of stack bytes pushed");

	abs_call_leg_a:
		assert property (take_s(cmsv_pkg::OP_CALL_ABS, 1'b1) |-> done_after_3_s)
		else $error("legacy absolute call not three cycles");

	abs_call_ext_a:
		assert property (take_s(cmsv_pkg::OP_CALL_ABS, 1'b0) |-> done_after_4_s)
		else $error("extended absolute call not four cycles");

	fixed_call_time_a:
		assert property (take_s(cmsv_pkg::OP_CALL_FIXED, 1'b1)
			|-> ##1 !target_valid_out [*2] ##1 target_valid_out)
		else $error("legacy fixed call not two cycles");

	fixed_call_ext_a:
		assert property (take_s(cmsv_pkg::OP_CALL_FIXED, 1'b0) |-> done_after_3_s)
		else $error("extended fixed call not three cycles");

	far_legacy_a:
		assert property ((take_s(cmsv_pkg::OP_FAR_JUMP, 1'b1)
			or take_s(cmsv_pkg::OP_FAR_CALL, 1'b1)) |=> illegal_out && !busy_out)
		else $error("far operation accepted in legacy mode");

	far_ext_a:
		assert property (take_s(cmsv_pkg::OP_FAR_JUMP, 1'b0) |=> !illegal_out && busy_out)
		else $error("far jump refused in extended mode");

	bank_write_a:
		assert property (reg_wr_in && (reg_addr_in == cmsv_pkg::REG_SBS)
			|=> stack_bank_out == $past(reg_wdata_in[0]))
		else $error("stack bank does not follow register write");

	vec_edge_a:
		assert property (op_valid_in && !busy_out && (op_kind_in == cmsv_pkg::OP_VEC_LOOKUP)
			&& (operand_in[2:0] == cmsv_pkg::SRC_EDGE_A)
			|-> ##3 target_valid_out && (target_pc_out == cmsv_pkg::VEC_EDGE_A))
		else $error("edge_irq_a vector address wrong");

	vec_reset_a:
		assert property (op_valid_in && !busy_out && (op_kind_in == cmsv_pkg::OP_VEC_LOOKUP)
			&& (operand_in[2:0] == cmsv_pkg::SRC_RESET)
			|-> ##3 target_valid_out && (target_pc_out == cmsv_pkg::VEC_RESET))
		else $error("reset vector address wrong");

	vec_serial_a:
		assert property (op_valid_in && !busy_out && (op_kind_in == cmsv_pkg::OP_VEC_LOOKUP)
			&& (operand_in[2:0] == cmsv_pkg::SRC_SERIAL)
			|-> ##3 target_valid_out && (target_pc_out == cmsv_pkg::VEC_SERIAL))
		else $error("serial vector address wrong");

	vec_timer_a:
		assert property (op_valid_in && !busy_out && (op_kind_in == cmsv_pkg::OP_VEC_LOOKUP)
			&& (operand_in[2:0] == cmsv_pkg::SRC_TMR12)
			|-> ##3 target_valid_out && (target_pc_out == cmsv_pkg::VEC_TMR12))
		else $error("timer one or two vector address wrong");

	table_range_a:
		assert property (op_valid_in && !busy_out && (op_kind_in == cmsv_pkg::OP_TABLE)
			&& ((operand_in < cmsv_pkg::TABLE_LO) || (operand_in > cmsv_pkg::TABLE_HI))
			|=> illegal_out)
		else $error("table reference outside its area accepted");

	table_ok_a:
		assert property (op_valid_in && !busy_out && (op_kind_in == cmsv_pkg::OP_TABLE)
			&& (operand_in >= cmsv_pkg::TABLE_LO) && (operand_in <= cmsv_pkg::TABLE_HI)
			&& !operand_in[0] |=> busy_out && !illegal_out)
		else $error("table reference inside its area refused");

	block_jump_a:
		assert property (op_valid_in && !busy_out && (op_kind_in == cmsv_pkg::OP_BLOCK_JUMP)
			|-> ##3 target_valid_out && (target_pc_out[13:12] == $past(pc_in[13:12], 3)))
		else $error("block jump left the current block");

	rel_range_a:
		assert property (op_valid_in && !busy_out && (op_kind_in == cmsv_pkg::OP_REL_JUMP)
			&& (operand_in[5:1] == 5'h00) |=> illegal_out)
		else $error("relative jump offset 0 or 1 accepted");

	page_jump_a:
		assert property (op_valid_in && !busy_out && (op_kind_in == cmsv_pkg::OP_PAGE_DE)
			|-> ##4 target_valid_out && (target_pc_out[13:8] == $past(pc_in[13:8], 4))
			&& (target_pc_out[7:0] == $past(data_in[7:0], 4)))
		else $error("page jump changed the upper program counter bits");

	upper_byte_a:
		assert property (push_valid_out && (push_index_out == 2'h2)
			|-> push_data_out == {6'h00, hp_ret[13:12]})
		else $error("third stack byte lacks upper program counter bits");

endmodule : cmsv_top

// file: design/cmsv_vec_map.sv
// vector table addresses and vector entry decode
`timescale 1ns/1ps
module cmsv_vec_map (
	input logic [2:0] src_in,
	input logic [15:0] entry_in,
	output logic [13:0] vec_addr_out,
	output logic vec_ok_out,
	output logic entry_mbe_out,
	output logic entry_rbe_out,
	output logic [13:0] entry_start_out
);

	always_comb
	begin
		vec_ok_out = 1'b1;
		unique case (src_in)
			cmsv_pkg::SRC_RESET: vec_addr_out = cmsv_pkg::VEC_RESET;
			cmsv_pkg::SRC_ITMR_B: vec_addr_out = cmsv_pkg::VEC_ITMR_B;
			cmsv_pkg::SRC_EDGE_A: vec_addr_out = cmsv_pkg::VEC_EDGE_A;
			cmsv_pkg::SRC_SERIAL: vec_addr_out = cmsv_pkg::VEC_SERIAL;
			cmsv_pkg::SRC_TMR0: vec_addr_out = cmsv_pkg::VEC_TMR0;
			cmsv_pkg::SRC_TMR12: vec_addr_out = cmsv_pkg::VEC_TMR12;
			default:
			begin
				vec_addr_out = cmsv_pkg::VEC_RESET;
				vec_ok_out = 1'b0;
			end
		endcase
	end

	// upper byte: two flags then 6 address bits, lower byte: 8 address bits
	assign entry_mbe_out = entry_in[cmsv_pkg::ENT_MBE_BIT];
	assign entry_rbe_out = entry_in[cmsv_pkg::ENT_RBE_BIT];
	assign entry_start_out = entry_in[cmsv_pkg::PC_MSB:0];

endmodule : cmsv_vec_map
